/* File: inc/uart_baud_rx_pkg.sv */
// Constants, register map and state types for the UART baud generator and receive FIFO.
// Assumes a single 250 MHz port clock and a plain one-cycle register port.
// Summary of operation
// [R1] Data register: write transmits, read receives
// [R2] Bit rate is clock over divisor+mod/8
// [R3] Software keeps divisor within range limits
// [R4] Software writes low divisor byte first
// [R5] No divisor change during transmission
// [R6] Three sampling points move with range select; the code moves only pt_a and pt_b, pt_c stays at half+2
// [R7] No range select change during transmission
// [R8] Modulation carry stretches bit by one clock
// [R9] Software computes divisor and modulation values
// [R10] Trigger code sets receive-available flag
// [R11] Trigger with enable raises interrupt request
// [R12] Receive FIFO empty after reset
// [R13] Unread counter tracks pushes and reads
// [R14] Fifth byte held, sixth overwrites, count four
// [R15] Counter cleared on reset and enable set
// [R16] Counter read-only, unused bits read zero
// [R17] Free-running 16-bit timer times each bit
// [R18] Remote sender uses two stop bits
// [R19] Software may pick two-byte trigger level
// [R20] Overrun or available flag gates interrupt request
// [R21] Disable clears counter, buffer, flags; sets tx flags
// [R22] Modulation accumulator restarts at every start bit
// [R23] Data read pops oldest FIFO byte
package uart_baud_rx_pkg;
  localparam int unsigned ADDR_W = 3;
  // Register offsets
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_DIV_LO = 3'h1;
  localparam logic [2:0] OFS_DIV_HI = 3'h2;
  localparam logic [2:0] OFS_FMC = 3'h3;
  localparam logic [2:0] OFS_COUNT = 3'h4;
  localparam logic [2:0] OFS_CTRL = 3'h5;
  localparam logic [2:0] OFS_STATUS = 3'h6;
  // Field positions
  localparam int unsigned FMC_MOD_LSB = 3;
  localparam int unsigned FMC_RANGE_BIT = 2;
  localparam int unsigned FMC_TRIG_LSB = 0;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_RIE_BIT = 1;
  localparam int unsigned ST_AVAIL_BIT = 0;
  localparam int unsigned ST_OVERRUN_BIT = 1;
  localparam int unsigned ST_TX_IDLE_BIT = 2;
  localparam int unsigned ST_TX_EMPTY_BIT = 3;
  // Values after reset
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [5:0] FMC_RESET = 6'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Frame counts
  localparam logic [3:0] RX_DATA_BITS = 4'h8;
  localparam logic [3:0] TX_FRAME_BITS = 4'hB;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage : uart_baud_rx_pkg

/* File: rtl/uart_baud_rx_fifo.sv */
// Baud generator, 8N1 receiver with four-byte FIFO and 8N2 transmitter.
// Assumes rx_pin is asynchronous; register port is on ref_clk.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module bit_period_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic restart,
  input wire logic [15:0] divisor,
  input wire logic [2:0] modulation,
  // Timing
  output logic [15:0] count,
  output logic bit_end
);
  logic [15:0] cnt_q, cnt_d, last;
  logic [2:0] acc_q, acc_d;
  logic ext_q, ext_d;
  logic [3:0] sum;

  always_comb begin
    last = divisor - 16'h0001 + {15'h0000, ext_q}; // R2 R8
    bit_end = (cnt_q == last) && !restart;
    sum = {1'b0, acc_q} + {1'b0, modulation}; // R8
    cnt_d = cnt_q + 16'h0001; // R17
    acc_d = acc_q;
    ext_d = ext_q;
    if (restart) begin
      cnt_d = 16'h0000;
      {ext_d, acc_d} = {1'b0, modulation}; // R22
    end else if (bit_end) begin
      cnt_d = 16'h0000;
      {ext_d, acc_d} = sum; // R8
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      acc_q <= 3'h0;
      ext_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      ext_q <= ext_d;
    end
  end

  assign count = cnt_q;
endmodule : bit_period_timer

module uart_baud_rx_fifo
  import uart_baud_rx_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Serial pins
  input wire logic rx_pin,
  output logic tx_pin,
  // Interrupt request flag
  output logic irq_request
);
  // Registers
  logic [7:0] div_lo_q, div_lo_d, div_hi_q, div_hi_d, rdata_q, rdata_d;
  logic [5:0] fmc_q, fmc_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic port_enable_bit, rx_interrupt_enable, divisor_range_select;
  logic [15:0] bit_divisor;
  logic [2:0] modulation_fraction;
  logic [1:0] rx_trigger_level;
  logic wr_data, rd_data, rd_status, en_set;

  // Receive FIFO
  logic [7:0] mem_q [FIFO_DEPTH];
  logic [7:0] mem_d [FIFO_DEPTH];
  logic [1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [2:0] rx_unread_count_q, rx_unread_count_d, cnt_tmp;
  logic [7:0] hold_q, hold_d;
  logic hold_valid_q, hold_valid_d;
  logic rx_available_flag_q, rx_available_flag_d, overrun_flag_q, overrun_flag_d;
  logic irq_q, irq_d, pop, trig_hit;

  // Receiver
  logic rx_s1_q, rx_s2_q;
  rx_state_t rx_state_q, rx_state_d;
  logic [7:0] rx_shift_q, rx_shift_d;
  logic [3:0] rx_bits_q, rx_bits_d;
  logic samp_a_q, samp_a_d, samp_b_q, samp_b_d;
  logic rx_restart, rx_bit_end, vote_ok, vote, deliver;
  logic [15:0] rx_count, half, pt_a, pt_b, pt_c;

  // Transmitter
  tx_state_t tx_state_q, tx_state_d;
  logic [7:0] tx_buf_q, tx_buf_d;
  logic tx_full_q, tx_full_d, tx_pin_q, tx_pin_d;
  logic [10:0] tx_shift_q, tx_shift_d;
  logic [3:0] tx_bits_q, tx_bits_d;
  logic tx_restart, tx_bit_end;

  assign port_enable_bit = ctrl_q[CTRL_EN_BIT];
  assign rx_interrupt_enable = ctrl_q[CTRL_RIE_BIT];
  assign bit_divisor = {div_hi_q, div_lo_q}; // R3 R4 R5
  assign modulation_fraction = fmc_q[FMC_MOD_LSB +: 3];
  assign divisor_range_select = fmc_q[FMC_RANGE_BIT]; // R7
  assign rx_trigger_level = fmc_q[FMC_TRIG_LSB +: 2]; // R19
  assign wr_data = reg_write && (reg_addr == OFS_DATA);
  assign rd_data = reg_read && (reg_addr == OFS_DATA);
  assign rd_status = reg_read && (reg_addr == OFS_STATUS);
  assign en_set = reg_write && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_EN_BIT];

  // Register file
  always_comb begin
    div_lo_d = div_lo_q;
    div_hi_d = div_hi_q;
    fmc_d = fmc_q;
    ctrl_d = ctrl_q;
    rdata_d = 8'h00;
    if (reg_write) begin
      case (reg_addr)
        OFS_DIV_LO: div_lo_d = reg_wdata;
        OFS_DIV_HI: div_hi_d = reg_wdata;
        OFS_FMC: fmc_d = reg_wdata[5:0];
        OFS_CTRL: ctrl_d = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        OFS_DATA: rdata_d = mem_q[rd_ptr_q]; // R1 R23
        OFS_DIV_LO: rdata_d = div_lo_q;
        OFS_DIV_HI: rdata_d = div_hi_q;
        OFS_FMC: rdata_d = {2'h0, fmc_q}; // R16
        OFS_COUNT: rdata_d = {5'h00, rx_unread_count_q}; // R16
        OFS_CTRL: rdata_d = {6'h00, ctrl_q};
        OFS_STATUS: rdata_d = {4'h0, !tx_full_q, tx_state_q == TX_IDLE,
                               overrun_flag_q, rx_available_flag_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_lo_q <= DIV_RESET;
      div_hi_q <= DIV_RESET;
      fmc_q <= FMC_RESET;
      ctrl_q <= CTRL_RESET;
      rdata_q <= 8'h00;
    end else begin
      div_lo_q <= div_lo_d;
      div_hi_q <= div_hi_d;
      fmc_q <= fmc_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // Two-flop synchroniser; only rx_s2_q feeds logic
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  assign rx_restart = port_enable_bit && (rx_state_q == RX_IDLE) && !rx_s2_q;
  assign tx_restart = port_enable_bit && (tx_state_q == TX_IDLE) && tx_full_q;

  bit_period_timer u_rx_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(rx_restart),
    .divisor(bit_divisor),
    .modulation(modulation_fraction),
    .count(rx_count),
    .bit_end(rx_bit_end)
  );

  bit_period_timer u_tx_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(tx_restart),
    .divisor(bit_divisor),
    .modulation(modulation_fraction),
    .count(),
    .bit_end(tx_bit_end)
  );

  // Sampling points; range 1 moves the first two a clock earlier for short divisors
  always_comb begin
    half = {1'b0, bit_divisor[15:1]};
    pt_a = divisor_range_select ? half - 16'h0001 : half; // R6
    pt_b = divisor_range_select ? half : half + 16'h0001; // R6
    pt_c = half + 16'h0002; // R6
    vote_ok = (rx_state_q != RX_IDLE) && (rx_count == pt_c);
  end

  // Receiver
  always_comb begin
    rx_state_d = rx_state_q;
    rx_shift_d = rx_shift_q;
    rx_bits_d = rx_bits_q;
    samp_a_d = (rx_count == pt_a) ? rx_s2_q : samp_a_q;
    samp_b_d = (rx_count == pt_b) ? rx_s2_q : samp_b_q;
    vote = (samp_a_q & samp_b_q) | (samp_a_q & rx_s2_q) | (samp_b_q & rx_s2_q);
    deliver = 1'b0;
    case (rx_state_q)
      RX_IDLE: begin
        rx_bits_d = 4'h0;
        if (rx_restart) begin
          rx_state_d = RX_START;
        end
      end
      RX_START: begin
        if (vote_ok && vote) begin
          rx_state_d = RX_IDLE;
        end else if (rx_bit_end) begin
          rx_state_d = RX_DATA;
        end
      end
      RX_DATA: begin
        if (vote_ok) begin
          rx_shift_d = {vote, rx_shift_q[7:1]};
          rx_bits_d = rx_bits_q + 4'h1;
        end
        if (rx_bit_end && (rx_bits_q == RX_DATA_BITS)) begin
          rx_state_d = RX_STOP;
        end
      end
      RX_STOP: begin
        // Back to idle at mid stop bit so the next start edge resynchronises
        if (vote_ok) begin
          deliver = vote;
          rx_state_d = RX_IDLE;
        end
      end
      default: rx_state_d = RX_IDLE;
    endcase
    if (!port_enable_bit) begin
      rx_state_d = RX_IDLE; // R21
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_state_q <= RX_IDLE;
      rx_shift_q <= 8'h00;
      rx_bits_q <= 4'h0;
      samp_a_q <= 1'b1;
      samp_b_q <= 1'b1;
    end else begin
      rx_state_q <= rx_state_d;
      rx_shift_q <= rx_shift_d;
      rx_bits_q <= rx_bits_d;
      samp_a_q <= samp_a_d;
      samp_b_q <= samp_b_d;
    end
  end

  // Receive FIFO, holding stage, flags and interrupt request
  always_comb begin
    mem_d = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    hold_d = hold_q;
    hold_valid_d = hold_valid_q;
    overrun_flag_d = overrun_flag_q && !rd_status;
    pop = rd_data && (rx_unread_count_q != 3'h0); // R23
    cnt_tmp = rx_unread_count_q - {2'h0, pop}; // R13
    if (pop) begin
      rd_ptr_d = rd_ptr_q + 2'h1;
    end
    if (pop && hold_valid_q) begin
      mem_d[wr_ptr_q] = hold_q;
      wr_ptr_d = wr_ptr_q + 2'h1;
      cnt_tmp = cnt_tmp + 3'h1;
      hold_valid_d = 1'b0;
    end
    if (deliver) begin
      if (cnt_tmp < 3'(FIFO_DEPTH) && !(pop && hold_valid_q)) begin
        mem_d[wr_ptr_d] = rx_shift_q;
        wr_ptr_d = wr_ptr_d + 2'h1;
        cnt_tmp = cnt_tmp + 3'h1; // R13
      end else begin
        hold_d = rx_shift_q; // R14
        hold_valid_d = 1'b1;
        overrun_flag_d = 1'b1; // R14
      end
    end
    rx_unread_count_d = cnt_tmp;
    if (en_set || !port_enable_bit) begin
      rx_unread_count_d = 3'h0; // R15 R21
      wr_ptr_d = 2'h0;
      rd_ptr_d = 2'h0;
      hold_valid_d = 1'b0;
      overrun_flag_d = 1'b0;
    end
    case (rx_trigger_level)
      2'h0: trig_hit = rx_unread_count_d >= 3'h4; // R10
      2'h1: trig_hit = rx_unread_count_d >= 3'h1;
      2'h2: trig_hit = rx_unread_count_d >= 3'h2;
      default: trig_hit = rx_unread_count_d >= 3'h3;
    endcase
    rx_available_flag_d = trig_hit; // R10
    irq_d = rx_interrupt_enable && (trig_hit || overrun_flag_d); // R11 R20
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_q <= '{default: 8'h00};
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      rx_unread_count_q <= 3'h0; // R12 R15
      hold_q <= 8'h00;
      hold_valid_q <= 1'b0;
      rx_available_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      rx_unread_count_q <= rx_unread_count_d;
      hold_q <= hold_d;
      hold_valid_q <= hold_valid_d;
      rx_available_flag_q <= rx_available_flag_d;
      overrun_flag_q <= overrun_flag_d;
      irq_q <= irq_d;
    end
  end

  // Transmitter: start, eight data bits, two stop bits
  always_comb begin
    tx_state_d = tx_state_q;
    tx_buf_d = tx_buf_q;
    tx_full_d = tx_full_q;
    tx_shift_d = tx_shift_q;
    tx_bits_d = tx_bits_q;
    tx_pin_d = 1'b1;
    case (tx_state_q)
      TX_IDLE: begin
        if (tx_restart) begin
          tx_shift_d = {2'h3, tx_buf_q, 1'b0};
          tx_bits_d = 4'h0;
          tx_full_d = 1'b0;
          tx_state_d = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        tx_pin_d = tx_shift_q[0];
        if (tx_bit_end) begin
          tx_shift_d = {1'b1, tx_shift_q[10:1]};
          tx_bits_d = tx_bits_q + 4'h1;
          if (tx_bits_q == TX_FRAME_BITS - 4'h1) begin
            tx_state_d = TX_IDLE;
            tx_pin_d = 1'b1;
          end
        end
      end
      default: tx_state_d = TX_IDLE;
    endcase
    if (wr_data && port_enable_bit && !tx_full_q) begin
      tx_buf_d = reg_wdata; // R1
      tx_full_d = 1'b1;
    end
    if (!port_enable_bit) begin
      tx_state_d = TX_IDLE; // R21
      tx_full_d = 1'b0;
      tx_pin_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_state_q <= TX_IDLE;
      tx_buf_q <= 8'h00;
      tx_full_q <= 1'b0;
      tx_shift_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
      tx_pin_q <= 1'b1;
    end else begin
      tx_state_q <= tx_state_d;
      tx_buf_q <= tx_buf_d;
      tx_full_q <= tx_full_d;
      tx_shift_q <= tx_shift_d;
      tx_bits_q <= tx_bits_d;
      tx_pin_q <= tx_pin_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign tx_pin = tx_pin_q;
  assign irq_request = irq_q;
endmodule : uart_baud_rx_fifo

`default_nettype wire

/* File: test/uart_baud_rx_fifo_checker.sv */
// Port checker for the UART baud generator and receive FIFO.
// Assumes the package register map; bound to the top module.
`timescale 1ns/10ps
`default_nettype none
module uart_baud_rx_fifo_checker
  import uart_baud_rx_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic tx_pin,
  input wire logic irq_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic ctl_wr;
  logic rd_cnt;
  assign ctl_wr = reg_write && reg_addr == OFS_CTRL;
  assign rd_cnt = reg_read && reg_addr == OFS_COUNT;
  property p_quiet;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside slot");
  property p_cnt_bits;
    rd_cnt |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_cnt_bits: assert property (p_cnt_bits) else $error("count upper bits");
  property p_cnt_max;
    rd_cnt |=> reg_rdata[2:0] <= 3'h4;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("count above four");
  property p_fmc_bits;
    reg_read && reg_addr == OFS_FMC |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_fmc_bits: assert property (p_fmc_bits) else $error("fifo control upper bits");
  property p_unmapped;
    reg_read && reg_addr == 3'h7 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_irq_off;
    ctl_wr && !reg_wdata[CTRL_RIE_BIT] ##1 !ctl_wr |=> !irq_request;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_cnt_clear;
    ctl_wr && reg_wdata[CTRL_EN_BIT] ##2 rd_cnt |=> reg_rdata == 8'h00;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");
  property p_disable;
    ctl_wr && !reg_wdata[CTRL_EN_BIT] ##2 reg_read && reg_addr == OFS_STATUS
      |=> reg_rdata[3:0] == 4'hC;
  endproperty
  a_disable: assert property (p_disable) else $error("status after disable");
  property p_tx_bit;
    $fell(tx_pin) |-> !tx_pin [*7];
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("tx bit too short");
  c_full: cover property (rd_cnt ##1 reg_rdata == 8'h04);
  c_irq: cover property ($rose(irq_request));
  c_tx: cover property ($fell(tx_pin));
endmodule : uart_baud_rx_fifo_checker

bind uart_baud_rx_fifo uart_baud_rx_fifo_checker uart_baud_rx_fifo_checker_inst (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_pin(tx_pin),
  .irq_request(irq_request));
`default_nettype wire

/* File: test/uart_remote_model.sv */
// Remote serial sender driving the block's receive pin.
// Assumes the bench passes the divisor and modulation in use.
`timescale 1ns/10ps
`default_nettype none
module uart_remote_model (
  // Clock
  input wire logic ref_clk,
  // Serial line, idle high like a pulled-up pin
  output logic rx_pin
);
  initial rx_pin = 1'b1;
  task automatic send(input logic [7:0] b, input logic [15:0] dv, input logic [2:0] md,
                      input int gap);
    logic [10:0] fr;
    logic [3:0] sum;
    logic [2:0] acc;
    fr = {2'b11, b, 1'b0};
    acc = 3'h0;
    for (int k = 0; k < 11; k++) begin
      sum = {1'b0, acc} + {1'b0, md};
      acc = sum[2:0];
      @(posedge ref_clk);
      rx_pin <= fr[k];
      repeat (dv + sum[3] - 1) @(posedge ref_clk);
    end
    repeat (gap) @(posedge ref_clk);
  endtask : send
endmodule : uart_remote_model
`default_nettype wire

/* File: test/test_uart_baud_rx_fifo.sv */
// Self-checking bench for the UART baud generator and receive FIFO.
// Assumes the remote model on rx_pin and a 250 MHz ref_clk.
`timescale 1ns/10ps
`default_nettype none
module test_uart_baud_rx_fifo
  import uart_baud_rx_pkg::*;
;
  logic ref_clk, reset, reg_write, reg_read, tx_pin, irq_request, rx_pin;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int err_total, n_checks;
  uart_baud_rx_fifo uart_baud_rx_fifo_inst (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq_request(irq_request));
  uart_remote_model uart_remote_model_inst (.ref_clk(ref_clk), .rx_pin(rx_pin));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : rd
  task automatic rc(input string nm, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rc
  function automatic logic avail_exp(input logic [1:0] tr, input int n);
    return (tr == 2'h0) ? (n >= 4) : (n >= tr);
  endfunction : avail_exp
  task automatic tx_check(input logic [7:0] b, input logic [15:0] dv, input logic [2:0] md);
    logic [10:0] fr;
    logic [3:0] sum;
    logic [2:0] acc;
    int w;
    fr = {2'b11, b, 1'b0};
    acc = 3'h0;
    w = 0;
    wr(OFS_DATA, b);
    while (tx_pin !== 1'b0) begin
      @(posedge ref_clk);
      w++;
      if (w > 64) begin
        $display("mismatch tx start expected 0 seen %b", tx_pin);
        err_total++;
        end_sim();
      end
    end
    // Sample mid-bit so a one-clock offset of the start edge is harmless
    for (int k = 0; k < 11; k++) begin
      sum = {1'b0, acc} + {1'b0, md};
      acc = sum[2:0];
      repeat ((dv + sum[3]) / 2) @(posedge ref_clk);
      chk("tx bit", {7'h00, fr[k]}, {7'h00, tx_pin});
      repeat (dv + sum[3] - (dv + sum[3]) / 2) @(posedge ref_clk);
    end
  endtask : tx_check
  initial begin
    logic [7:0] st;
    logic [7:0] by [6];
    logic [15:0] dv;
    logic [2:0] md;
    logic rg, rie, ex;
    int n;
    err_total = 0;
    n_checks = 0;
    reset = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    void'($urandom(68337));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 1; a < 8; a++) begin
      if (a != 5 && a != 6) rc("reset value", a[2:0], 8'h00);
    end
    wr(OFS_COUNT, 8'hFF);
    wr(3'h7, 8'hFF);
    rc("count read-only", OFS_COUNT, 8'h00);
    rc("unmapped", 3'h7, 8'h00);
    for (int c = 0; c < 2; c++) begin
      rg = c[0];
      dv = rg ? 16'(8 + $urandom_range(7)) : 16'(16 + $urandom_range(24));
      md = (c == 0) ? 3'h7 : 3'($urandom_range(7));
      // Divisor only changes while the transmitter is idle
      wr(OFS_DIV_LO, dv[7:0]);
      wr(OFS_DIV_HI, dv[15:8]);
      rc("divisor low", OFS_DIV_LO, dv[7:0]);
      for (int t = 0; t < 4; t++) begin
        // Interrupt enable forced both ways in every pass, random otherwise
        rie = (t == 1) ? 1'b1 : (t == 2) ? 1'b0 : 1'($urandom_range(1));
        wr(OFS_FMC, {2'h3, md, rg, t[1:0]});
        rc("fifo control", OFS_FMC, {2'h0, md, rg, t[1:0]});
        wr(OFS_CTRL, {6'h00, rie, 1'b1});
        rc("count cleared", OFS_COUNT, 8'h00);
        for (int i = 0; i < 6; i++) begin
          by[i] = 8'($urandom);
          uart_remote_model_inst.send(by[i], dv, md, $urandom_range(dv));
          n = (i < 4) ? i + 1 : 4;
          rc("count", OFS_COUNT, 8'(n));
          ex = rie && (avail_exp(t[1:0], n) || i == 4);
          chk("irq", {7'h00, ex}, {7'h00, irq_request});
          rd(OFS_STATUS, st);
          chk("avail", {7'h00, avail_exp(t[1:0], n)}, {7'h00, st[0]});
          if (i <= 4) chk("overrun", {7'h00, i == 4}, {7'h00, st[1]});
        end
        for (int i = 0; i < 3; i++) begin
          rc("rx data", OFS_DATA, by[i]);
          rc("count after read", OFS_COUNT, 8'(i == 0 ? 4 : 4 - i));
        end
      end
      tx_check(8'($urandom), dv, md);
      repeat (4) @(posedge ref_clk);
    end
    wr(OFS_CTRL, 8'h00);
    rd(OFS_STATUS, st);
    chk("status disabled", 8'h0C, {4'h0, st[3:0]});
    rc("count disabled", OFS_COUNT, 8'h00);
    end_sim();
  end
endmodule : test_uart_baud_rx_fifo
`default_nettype wire
